/* dram_sr_defs.svh */
// Offsets, field positions, command codes and timing counts for the
// self refresh / Vref command checker. Included by bare name.
`ifndef DRAM_SR_DEFS_SVH
`define DRAM_SR_DEFS_SVH

`define REF_CLK_MHZ      40
`define CYC_UP(ns)       ((((ns) * `REF_CLK_MHZ) + 999) / 1000)

// Times in ns
`define MIN_SR_RES_NS    15
`define SR_EXIT_REC_NS   190
`define HC_ON_WAIT_NS    200
`define HC_OFF_WAIT_NS   100
`define VREF_SHORT_NS    80
`define VREF_MIDDLE_NS   175

// Derived ref_clk counts, least times rounded up
`define MIN_SR_RES_CYC   `CYC_UP(`MIN_SR_RES_NS)
`define SR_EXIT_REC_CYC  `CYC_UP(`SR_EXIT_REC_NS)
`define HC_ON_WAIT_CYC   `CYC_UP(`HC_ON_WAIT_NS)
`define HC_OFF_WAIT_CYC  `CYC_UP(`HC_OFF_WAIT_NS)
`define VREF_SHORT_CYC   `CYC_UP(`VREF_SHORT_NS)
`define VREF_MIDDLE_CYC  `CYC_UP(`VREF_MIDDLE_NS)

// Burst and refresh figures
`define MRR_BL           16
`define PB_REF_COUNT     8

// Mode register addresses and fields
`define MR_CA_VREF       6'h0c
`define MR_MODE13        6'h0d
`define MR_BANK_MASK     6'h10
`define MR_SEG_MASK      6'h11
`define MODE_CONTROL_REGISTER_THIRTEEN_HC_BIT      3
`define CA_REFERENCE_VOLTAGE_SETTING_CODE_MSB    5
`define CA_REFERENCE_VOLTAGE_SETTING_RANGE_BIT   6
`define CA_REFERENCE_VOLTAGE_SETTING_RESET       8'h4d
`define MODE_CONTROL_REGISTER_THIRTEEN_RESET       8'h00

// First-edge command codes on ca[4:0]
`define CA_MRW1          5'h06
`define CA_MRW2          5'h12
`define CA_MRR1          5'h0e
`define CA_CAS2          5'h0a
`define CA_MPC           5'h01
`define CA_SRE           5'h18
`define CA_SRX           5'h14
`define CA_REFAB         5'h08
`define CA_REFPB         5'h09
`define CA_WR1           5'h04

`endif

/* dram_sr_pkg.sv */
// Types shared by the command checker modules.
// Assumes dram_sr_defs.svh supplies all numeric constants.
package dram_sr_pkg;

  typedef enum logic [3:0] {
    C_MRW1, C_MRW2, C_MRR1, C_CAS2, C_MPC, C_SRE, C_SRX,
    C_REFAB, C_REFPB, C_WR1, C_OTHER
  } cmd_e;

  typedef enum logic [1:0] {V_SHORT, V_MIDDLE, V_LONG} vref_class_e;

  typedef enum logic {D_IDLE, D_ARG} dec_state_e;

  typedef struct packed {
    dec_state_e  dec;
    cmd_e        cmd;
    logic        op_hi;
    logic        op7;
    logic [5:0]  mr_addr;
    logic        in_sr;
    logic        in_pd;
    logic        owed;
    logic [3:0]  pb_cnt;
    logic [7:0]  ca_reference_voltage_setting;
    logic [7:0]  mode_control_register_thirteen;
    logic [4:0]  beats;
    logic [7:0]  mrr_word;
    logic        mrr_valid;
    logic        viol;
    logic        post_ref;
    vref_class_e vcls;
  } ctrl_s;

endpackage

/* link_if.sv */
// Sampled link signals passed from the pin sampler to the checker.
// Assumes both ends run on ref_clk.
`timescale 1ns/1ps
`default_nettype none
interface link_if;
  logic       ck_rise;
  logic       cke;
  logic       cs;
  logic [5:0] ca;
  modport src (output ck_rise, cke, cs, ca);
  modport dst (input ck_rise, cke, cs, ca);
endinterface
`default_nettype wire

/* link_sampler.sv */
// Pin synchroniser and link clock edge finder.
// Assumes ck is much slower than ref_clk and free of glitches.
`timescale 1ns/1ps
`default_nettype none
module link_sampler
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // Pins
  input  wire logic       ck,
  input  wire logic       cke,
  input  wire logic       cs,
  input  wire logic [5:0] ca,
  // Sampled link
  link_if.src             lk
);
  typedef struct packed {
    logic [8:0] s1;
    logic [8:0] s2;
    logic       ck3;
  } samp_s;

  samp_s s_q;
  samp_s s_d;

  always_comb
  begin
    s_d     = s_q;
    s_d.s1  = {ck, cke, cs, ca};
    s_d.s2  = s_q.s1;
    // Edge detector reads the second stage and this third stage
    s_d.ck3 = s_q.s2[8];
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign lk.ck_rise = s_q.s2[8] & ~s_q.ck3;
  assign lk.cke     = s_q.s2[7];
  assign lk.cs      = s_q.s2[6];
  assign lk.ca      = s_q.s2[5:0];

  a_rise_pulse: assert property (@(posedge ref_clk) disable iff (srst)
    lk.ck_rise |=> !lk.ck_rise)
    else $error("ck_rise longer than one cycle");
endmodule
`default_nettype wire

/* wait_timer.sv */
// Loadable down counter; busy while the count is non-zero.
// Assumes tick is a one-cycle enable or tied high.
`timescale 1ns/1ps
`default_nettype none
module wait_timer #(
  parameter int W = 12
)
(
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         srst,
  // Control
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  input  wire logic         tick,
  // Status
  output logic              busy
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } tmr_s;

  tmr_s t_q;
  tmr_s t_d;

  always_comb
  begin
    t_d = t_q;
    if (start)
      t_d.cnt = load;
    else if (tick && t_q.cnt != '0)
      t_d.cnt = t_q.cnt - 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      t_q <= '0;
    else
      t_q <= t_d;
  end

  assign busy = (t_q.cnt != '0);

  a_timer_load: assert property (@(posedge ref_clk) disable iff (srst)
    start && load != '0 |=> busy && t_q.cnt == $past(load))
    else $error("timer did not load");
endmodule
`default_nettype wire

/* dram_sr_vref_ctrl.sv */
// Device-side command checker: self refresh, MRR, high-current Vref
// generator and CA Vref mode register.
// Assumes ck, cke, cs, ca arrive asynchronously from the controller.
//
// Operation
// RULE1 - Controller holds self refresh for minimum residency before exit.
// RULE2 - Until exit recovery ends only MRR, CAS-2, DES, MPC, MRW allowed.
// RULE3 - One refresh (8 per-bank or all-bank) owed before next entry.
// RULE4 - Owed refresh excluded from interval accounting, counted in window.
// RULE5 - In self refresh only MRR, CAS-2, exit, MPC, MRW are accepted.
// RULE6 - Power down may be entered and left inside self refresh.
// RULE7 - Mode register read returns data with burst length 16 only.
// RULE8 - Only deselect during the mode register read period.
// RULE9 - Write to MRR spacing is WL plus BL/2 plus 1 plus WTR.
// RULE10 - Write-to-read delay starts after last write data strobe edge.
// RULE11 - MODE_CONTROL_REGISTER_THIRTEEN bit 3 set enables high current, then deselect-only wait.
// RULE12 - MODE_CONTROL_REGISTER_THIRTEEN bit 3 clear disables high current, then deselect-only wait.
// RULE13 - Vref range and value changes accepted with high current off.
// RULE14 - CA_REFERENCE_VOLTAGE_SETTING holds CA Vref code in bits 5:0, range in bit 6.
// RULE15 - Vref writes spaced by short time, or middle for larger changes.
// RULE16 - Vref change classed short, middle within range, long across.
// RULE17 - Vref step time counts from the edge registering the write.
// RULE18 - Owed-refresh flag set at exit blocks the next entry.
`include "dram_sr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module dram_sr_vref_ctrl #(
  parameter int WL_NCK  = 6,
  parameter int WTR_NCK = 4,
  parameter int MRR_NCK = 8
)
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // Link pins
  input  wire logic       ck,
  input  wire logic       cke,
  input  wire logic       cs,
  input  wire logic [5:0] ca,
  // Mode register read data
  output logic [7:0]      mrr_data,
  output logic            mrr_data_valid,
  // Vref and generator state
  output logic [5:0]      ca_vref_code,
  output logic            ca_vref_range,
  output logic            hc_mode,
  output logic            vref_settling,
  output logic [1:0]      vref_class,
  // Power state and command violation
  output logic            sr_active,
  output logic            pd_active,
  output logic            refresh_owed,
  output logic            post_exit_ref,
  output logic            cmd_violation
);
  localparam int NT = 6;
  localparam int TW = 12;
  localparam int WTR_TOTAL = WL_NCK + `MRR_BL / 2 + 1 + WTR_NCK;

  link_if lk ();

  link_sampler u_samp
  (
    .ref_clk (ref_clk),
    .srst    (srst),
    .ck      (ck),
    .cke     (cke),
    .cs      (cs),
    .ca      (ca),
    .lk      (lk)
  );

  dram_sr_pkg::ctrl_s s;
  dram_sr_pkg::ctrl_s n;

  // Timers: 0 residency, 1 exit recovery, 2 generator wait,
  // 3 Vref spacing, 4 MRR period, 5 write-to-MRR
  logic [TW-1:0] t_load [NT];
  logic [NT-1:0] t_start;
  logic [NT-1:0] t_tick;
  logic [NT-1:0] t_busy;

  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++)
    begin : g_tmr
      wait_timer #(.W(TW)) u_tmr
      (
        .ref_clk (ref_clk),
        .srst    (srst),
        .start   (t_start[gi]),
        .load    (t_load[gi]),
        .tick    (t_tick[gi]),
        .busy    (t_busy[gi])
      );
    end
  endgenerate

  // ns timers run on every ref_clk, nCK timers on link edges
  assign t_tick = {lk.ck_rise, lk.ck_rise, 4'hf};

  function automatic dram_sr_pkg::cmd_e dec_cmd(input logic [4:0] code);
    case (code)
      `CA_MRW1:  dec_cmd = dram_sr_pkg::C_MRW1;
      `CA_MRW2:  dec_cmd = dram_sr_pkg::C_MRW2;
      `CA_MRR1:  dec_cmd = dram_sr_pkg::C_MRR1;
      `CA_CAS2:  dec_cmd = dram_sr_pkg::C_CAS2;
      `CA_MPC:   dec_cmd = dram_sr_pkg::C_MPC;
      `CA_SRE:   dec_cmd = dram_sr_pkg::C_SRE;
      `CA_SRX:   dec_cmd = dram_sr_pkg::C_SRX;
      `CA_REFAB: dec_cmd = dram_sr_pkg::C_REFAB;
      `CA_REFPB: dec_cmd = dram_sr_pkg::C_REFPB;
      `CA_WR1:   dec_cmd = dram_sr_pkg::C_WR1;
      default:   dec_cmd = dram_sr_pkg::C_OTHER;
    endcase
  endfunction

  // Command set usable inside self refresh and exit recovery
  function automatic logic sr_ok(input dram_sr_pkg::cmd_e c,
                                 input logic with_exit);
    sr_ok = c == dram_sr_pkg::C_MRR1 || c == dram_sr_pkg::C_CAS2 ||
            c == dram_sr_pkg::C_MPC || c == dram_sr_pkg::C_MRW1 ||
            c == dram_sr_pkg::C_MRW2 ||
            (with_exit && c == dram_sr_pkg::C_SRX);
  endfunction

  dram_sr_pkg::cmd_e          c;
  dram_sr_pkg::vref_class_e   cls;
  logic                       first_edge;
  logic                       arg_edge;
  logic [7:0]                 op;
  logic [5:0]                 vdiff;
  logic                       mask_mr;

  assign c          = dec_cmd(lk.ca[4:0]);
  assign first_edge = lk.ck_rise && lk.cke && lk.cs &&
                      s.dec == dram_sr_pkg::D_IDLE;
  assign arg_edge   = lk.ck_rise && s.dec == dram_sr_pkg::D_ARG;
  assign op         = {s.op7, s.op_hi, lk.ca};
  assign mask_mr    = s.mr_addr == `MR_BANK_MASK ||
                      s.mr_addr == `MR_SEG_MASK;
  assign vdiff      = op[5:0] > s.ca_reference_voltage_setting[5:0] ? op[5:0] - s.ca_reference_voltage_setting[5:0]
                                            : s.ca_reference_voltage_setting[5:0] - op[5:0];

  // Range change is a long move; one code is short
  always_comb
  begin
    if (op[`CA_REFERENCE_VOLTAGE_SETTING_RANGE_BIT] != s.ca_reference_voltage_setting[`CA_REFERENCE_VOLTAGE_SETTING_RANGE_BIT])
      cls = dram_sr_pkg::V_LONG; // RULE16
    else if (vdiff <= 6'h01)
      cls = dram_sr_pkg::V_SHORT; // RULE16
    else
      cls = dram_sr_pkg::V_MIDDLE; // RULE16
  end

  assign t_load[0] = TW'(`MIN_SR_RES_CYC);
  assign t_load[1] = TW'(`SR_EXIT_REC_CYC);
  assign t_load[2] = op[`MODE_CONTROL_REGISTER_THIRTEEN_HC_BIT] ? TW'(`HC_ON_WAIT_CYC)
                                      : TW'(`HC_OFF_WAIT_CYC);
  // Short spacing for one step, middle for anything larger
  assign t_load[3] = cls == dram_sr_pkg::V_SHORT ? TW'(`VREF_SHORT_CYC)
                                                 : TW'(`VREF_MIDDLE_CYC);
  assign t_load[4] = TW'(MRR_NCK);
  // Loaded at edge B and tested before the decrement, hence two less
  assign t_load[5] = TW'(WTR_TOTAL - 2); // RULE9 RULE10

  always_comb
  begin
    n          = s;
    n.viol     = 1'b0;
    n.post_ref = 1'b0;
    t_start    = '0;
    if (lk.ck_rise)
    begin
      n.in_pd = s.in_sr & ~lk.cke; // RULE6
      if (s.mrr_valid)
      begin
        n.beats     = s.beats - 5'h01;
        n.mrr_valid = s.beats != 5'h01; // RULE7
      end
    end
    if (first_edge)
    begin
      n.cmd   = c;
      n.op_hi = lk.ca[5];
      n.dec   = dram_sr_pkg::D_ARG;
      if (t_busy[4] || t_busy[2])
        n.viol = 1'b1; // RULE8 RULE11 RULE12
      if (s.in_sr && !sr_ok(c, 1'b1))
        n.viol = 1'b1; // RULE5
      if (t_busy[1] && !sr_ok(c, 1'b0))
        n.viol = 1'b1; // RULE2
      if (c == dram_sr_pkg::C_SRX && t_busy[0])
        n.viol = 1'b1; // RULE1
      if (c == dram_sr_pkg::C_SRE && s.owed)
        n.viol = 1'b1; // RULE3 RULE18
      if (c == dram_sr_pkg::C_MRR1 && t_busy[5])
        n.viol = 1'b1; // RULE9
    end
    else if (arg_edge)
    begin
      n.dec = dram_sr_pkg::D_IDLE;
      case (s.cmd)
        dram_sr_pkg::C_MRW1:
        begin
          n.mr_addr = lk.ca;
          n.op7     = s.op_hi;
        end
        dram_sr_pkg::C_MRW2:
        begin
          // Masking writes are refused while self refresh rules apply
          if ((s.in_sr || t_busy[1]) && mask_mr)
            n.viol = 1'b1; // RULE2 RULE5
          else if (s.mr_addr == `MR_CA_VREF)
          begin
            if (t_busy[3])
              n.viol = 1'b1; // RULE15
            n.ca_reference_voltage_setting     = op; // RULE13 RULE14
            n.vcls     = cls;
            t_start[3] = 1'b1; // RULE17
          end
          else if (s.mr_addr == `MR_MODE13)
          begin
            n.mode_control_register_thirteen     = op; // RULE11 RULE12
            t_start[2] = 1'b1;
          end
        end
        dram_sr_pkg::C_MRR1:
        begin
          t_start[4]  = 1'b1; // RULE8
          n.beats     = 5'(`MRR_BL); // RULE7
          n.mrr_valid = 1'b1;
          n.mrr_word  = lk.ca == `MR_CA_VREF ? s.ca_reference_voltage_setting :
                        lk.ca == `MR_MODE13  ? s.mode_control_register_thirteen : 8'h00;
        end
        dram_sr_pkg::C_SRE:
        begin
          n.in_sr    = 1'b1;
          t_start[0] = 1'b1; // RULE1
        end
        dram_sr_pkg::C_SRX:
        begin
          n.in_sr    = 1'b0;
          n.in_pd    = 1'b0;
          n.owed     = 1'b1; // RULE3 RULE18
          n.pb_cnt   = 4'h0;
          t_start[1] = 1'b1; // RULE2
        end
        dram_sr_pkg::C_REFAB:
        begin
          n.pb_cnt   = 4'h0;
          n.owed     = 1'b0; // RULE3
          n.post_ref = s.owed; // RULE4
        end
        dram_sr_pkg::C_REFPB:
        begin
          n.pb_cnt = s.pb_cnt + 4'h1;
          if (s.pb_cnt == 4'(`PB_REF_COUNT - 1))
          begin
            n.pb_cnt   = 4'h0;
            n.owed     = 1'b0; // RULE3
            n.post_ref = s.owed; // RULE4
          end
        end
        dram_sr_pkg::C_WR1:
          t_start[5] = 1'b1; // RULE10
        default:
          n.dec = dram_sr_pkg::D_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      s      <= '0;
      s.ca_reference_voltage_setting <= `CA_REFERENCE_VOLTAGE_SETTING_RESET;
      s.mode_control_register_thirteen <= `MODE_CONTROL_REGISTER_THIRTEEN_RESET;
    end
    else
      s <= n;
  end

  assign mrr_data       = s.mrr_word;
  assign mrr_data_valid = s.mrr_valid;
  assign ca_vref_code   = s.ca_reference_voltage_setting[`CA_REFERENCE_VOLTAGE_SETTING_CODE_MSB:0];
  assign ca_vref_range  = s.ca_reference_voltage_setting[`CA_REFERENCE_VOLTAGE_SETTING_RANGE_BIT];
  assign hc_mode        = s.mode_control_register_thirteen[`MODE_CONTROL_REGISTER_THIRTEEN_HC_BIT];
  assign vref_settling  = t_busy[3];
  assign vref_class     = s.vcls;
  assign sr_active      = s.in_sr;
  assign pd_active      = s.in_pd;
  assign refresh_owed   = s.owed;
  assign post_exit_ref  = s.post_ref;
  assign cmd_violation  = s.viol;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_mode_control_register_thirteen_write(logic b);
    arg_edge && s.cmd == dram_sr_pkg::C_MRW2 &&
    s.mr_addr == `MR_MODE13 && lk.ca[`MODE_CONTROL_REGISTER_THIRTEEN_HC_BIT] == b;
  endsequence

  sequence s_ca_reference_voltage_setting_write;
    arg_edge && s.cmd == dram_sr_pkg::C_MRW2 && s.mr_addr == `MR_CA_VREF &&
    !(s.in_sr || t_busy[1]) ;
  endsequence

  a_hc_on_wait: assert property ( // RULE11
    s_mode_control_register_thirteen_write(1'b1) |=> hc_mode && t_busy[2] ##1 t_busy[2])
    else $error("generator enable wait missing");
  a_hc_off_wait: assert property ( // RULE12
    s_mode_control_register_thirteen_write(1'b0) |=> !hc_mode && t_busy[2])
    else $error("generator disable wait missing");
  a_mrr_des_only: assert property ( // RULE8
    first_edge && t_busy[4] |=> cmd_violation)
    else $error("command in MRR period not flagged");
  a_pd_in_sr: assert property ( // RULE6
    pd_active |-> sr_active)
    else $error("power down tracked outside self refresh");
  a_mrr_sixteen: assert property ( // RULE7
    arg_edge && s.cmd == dram_sr_pkg::C_MRR1
    |=> mrr_data_valid && s.beats == 5'd16)
    else $error("MRR burst not sixteen");
  a_vref_store: assert property ( // RULE14
    s_ca_reference_voltage_setting_write |=> ca_vref_code == $past(lk.ca) &&
                     ca_vref_range == $past(s.op_hi) && vref_settling)
    else $error("CA_REFERENCE_VOLTAGE_SETTING fields not stored");
  a_vref_class: assert property ( // RULE16
    s_ca_reference_voltage_setting_write and (s.op_hi != s.ca_reference_voltage_setting[`CA_REFERENCE_VOLTAGE_SETTING_RANGE_BIT])
    |=> vref_class == dram_sr_pkg::V_LONG)
    else $error("range change not classed long");
  a_vref_spacing: assert property ( // RULE15
    s_ca_reference_voltage_setting_write and vref_settling |=> cmd_violation)
    else $error("close Vref writes not flagged");
  a_srx_early: assert property ( // RULE1
    first_edge && c == dram_sr_pkg::C_SRX && t_busy[0] |=> cmd_violation)
    else $error("early exit not flagged");
  a_owed_sre: assert property ( // RULE18
    first_edge && c == dram_sr_pkg::C_SRE && refresh_owed |=> cmd_violation)
    else $error("entry with refresh owed not flagged");
  a_post_ref: assert property ( // RULE4
    post_exit_ref |-> !refresh_owed && $past(refresh_owed))
    else $error("post exit refresh mismarked");
  a_wtr_start: assert property ( // RULE10
    arg_edge && s.cmd == dram_sr_pkg::C_WR1 |=> t_busy[5])
    else $error("write-to-MRR timer not started");
endmodule
`default_nettype wire

/* ctrl_model.sv */
// Controller-side model that drives the link pins of the command checker.
// Assumes the testbench calls its tasks from a single process.
`timescale 1ns/1ps
`default_nettype none
module ctrl_model
(
  // Link pins
  output logic       ck,
  output logic       cke,
  output logic       cs,
  output logic [5:0] ca
);
`include "dram_sr_defs.svh"

  initial
  begin
    ck  = 1'b0;
    cke = 1'b1;
    cs  = 1'b0;
    ca  = 6'h00;
  end

  // One link clock period; ck stays low between frames
  task automatic edge_out(input logic c_s, input logic [5:0] c_a);
    cs = c_s;
    ca = c_a;
    #100 ck = 1'b1;
    #100 ck = 1'b0;
  endtask

  // Deselect only; ca toggles since it is don't care
  task automatic des(input int n);
    repeat (n) edge_out(1'b0, ~ca);
  endtask

  task automatic set_cke(input logic v);
    cke = v;
  endtask

  task automatic send(input logic [4:0] op, input logic x,
                      input logic [5:0] arg);
    edge_out(1'b1, {x, op});
    edge_out(1'b0, arg);
  endtask

  // Two-part mode register write
  task automatic mrw(input logic [5:0] addr, input logic [7:0] val);
    send(`CA_MRW1, val[7], addr);
    send(`CA_MRW2, val[6], val[5:0]);
  endtask
endmodule
`default_nettype wire

/* dram_sr_vref_ctrl_test.sv */
// Self-checking testbench for the device-side command checker.
// Assumes ctrl_model drives the link pins; pulses counted on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module dram_sr_vref_ctrl_test;
`include "dram_sr_defs.svh"

  logic       ref_clk = 1'b0;
  logic       srst    = 1'b1;
  wire  logic ck;
  wire  logic cke;
  wire  logic cs;
  wire  logic [5:0] ca;
  wire  logic [7:0] mrr_data;
  wire  logic       mrr_data_valid;
  wire  logic [5:0] ca_vref_code;
  wire  logic       ca_vref_range;
  wire  logic       hc_mode;
  wire  logic       vref_settling;
  wire  logic [1:0] vref_class;
  wire  logic       sr_active;
  wire  logic       pd_active;
  wire  logic       refresh_owed;
  wire  logic       post_exit_ref;
  wire  logic       cmd_violation;
  int         bad_count = 0;
  int         cmp_count = 0;
  int         viol_n    = 0;
  int         post_n    = 0;
  int         beats     = 0;
  int         cyc       = 0;
  int         v0;
  logic [7:0] mrr_last  = 8'h00;

  always #12.5 ref_clk = ~ref_clk;

  ctrl_model ctl
  (
    .ck  (ck),
    .cke (cke),
    .cs  (cs),
    .ca  (ca)
  );

  dram_sr_vref_ctrl #(.WL_NCK(6), .WTR_NCK(4), .MRR_NCK(8)) uut
  (
    .ref_clk        (ref_clk),
    .srst           (srst),
    .ck             (ck),
    .cke            (cke),
    .cs             (cs),
    .ca             (ca),
    .mrr_data       (mrr_data),
    .mrr_data_valid (mrr_data_valid),
    .ca_vref_code   (ca_vref_code),
    .ca_vref_range  (ca_vref_range),
    .hc_mode        (hc_mode),
    .vref_settling  (vref_settling),
    .vref_class     (vref_class),
    .sr_active      (sr_active),
    .pd_active      (pd_active),
    .refresh_owed   (refresh_owed),
    .post_exit_ref  (post_exit_ref),
    .cmd_violation  (cmd_violation)
  );

  // One-cycle pulses would be missed by polling, so count them
  always @(posedge ref_clk)
  begin
    // Unknown pulses count too, so they cannot slip past
    if (cmd_violation !== 1'b0) viol_n <= viol_n + 1;
    if (post_exit_ref !== 1'b0) post_n <= post_n + 1;
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      bad_count++;
      final_report();
    end
  end

  always @(posedge ck)
  begin
    if (mrr_data_valid === 1'b1)
    begin
      beats++;
      mrr_last = mrr_data;
    end
  end

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic t_reset();
    check("vref_code", 8'(ca_vref_code), 8'(`CA_REFERENCE_VOLTAGE_SETTING_RESET & 8'h3f));
    check("vref_range", 8'(ca_vref_range), 8'h01);
    check("hc_mode", 8'(hc_mode), 8'h00);
    check("sr_active", 8'(sr_active), 8'h00);
    check("owed", 8'(refresh_owed), 8'h00);
    $display("test reset done");
  endtask

  task automatic t_vref();
    v0 = viol_n;
    ctl.mrw(`MR_CA_VREF, 8'h4e); settle();
    check("code_step", 8'(ca_vref_code), 8'h0e);
    check("class_short", 8'(vref_class), 8'h00);
    ctl.des(2);
    ctl.mrw(`MR_CA_VREF, 8'h53); settle();
    check("code_mid", 8'(ca_vref_code), 8'h13);
    check("class_mid", 8'(vref_class), 8'h01);
    check("settling_on", 8'(vref_settling), 8'h01);
    ctl.des(1); settle();
    check("settling_off", 8'(vref_settling), 8'h00);
    ctl.mrw(`MR_CA_VREF, 8'h13); settle();
    check("range_bit", 8'(ca_vref_range), 8'h00);
    check("class_long", 8'(vref_class), 8'h02);
    ctl.des(2); settle();
    check("vref_viol", 8'(viol_n - v0), 8'h00);
    $display("test vref done");
  endtask

  task automatic t_hc();
    v0 = viol_n;
    ctl.mrw(`MR_MODE13, 8'h08); settle();
    check("hc_on", 8'(hc_mode), 8'h01);
    ctl.des(2);
    ctl.mrw(`MR_MODE13, 8'h00); settle();
    check("hc_off", 8'(hc_mode), 8'h00);
    ctl.des(2); settle();
    check("hc_viol", 8'(viol_n - v0), 8'h00);
    $display("test generator done");
  endtask

  task automatic t_sr();
    ctl.send(`CA_SRE, 1'b0, 6'h00); settle();
    check("sr_enter", 8'(sr_active), 8'h01);
    ctl.set_cke(1'b0); ctl.des(2); settle();
    check("pd_enter", 8'(pd_active), 8'h01);
    ctl.set_cke(1'b1); ctl.des(2); settle();
    check("pd_exit", 8'(pd_active), 8'h00);
    v0 = viol_n;
    ctl.send(`CA_MPC, 1'b0, 6'h00); settle();
    check("sr_mpc", 8'(viol_n - v0), 8'h00);
    ctl.send(`CA_REFAB, 1'b1, 6'h00); settle();
    check("sr_illegal", 8'(viol_n - v0), 8'h01);
    ctl.des(2);
    ctl.send(`CA_SRX, 1'b0, 6'h00); settle();
    check("sr_exit", 8'(sr_active), 8'h00);
    check("owed_set", 8'(refresh_owed), 8'h01);
    ctl.des(2);
    v0 = viol_n;
    ctl.send(`CA_SRE, 1'b0, 6'h00); settle();
    check("sre_owed", 8'(viol_n - v0), 8'h01);
    ctl.des(2);
    ctl.send(`CA_SRX, 1'b0, 6'h00); ctl.des(2);
    v0 = post_n;
    for (int i = 0; i < `PB_REF_COUNT; i++)
    begin
      ctl.send(`CA_REFPB, 1'b0, 6'(i)); settle();
      check("owed_pb", 8'(refresh_owed), 8'(i < 7));
    end
    check("post_ref", 8'(post_n - v0), 8'h01);
    $display("test self refresh done");
  endtask

  task automatic t_mrr();
    v0 = viol_n;
    beats = 0;
    ctl.send(`CA_MRR1, 1'b0, `MR_CA_VREF);
    ctl.send(`CA_MPC, 1'b0, 6'h00); settle();
    check("mrr_busy", 8'(viol_n - v0), 8'h01);
    ctl.des(18); settle();
    check("mrr_beats", 8'(beats), 8'(`MRR_BL));
    check("mrr_data", mrr_last, 8'h13);
    check("mrr_done", 8'(mrr_data_valid), 8'h00);
    $display("test mode read done");
  endtask

  task automatic t_wtr();
    v0 = viol_n;
    ctl.send(`CA_WR1, 1'b0, 6'h00);
    ctl.send(`CA_MRR1, 1'b0, `MR_MODE13); settle();
    check("wtr_short", 8'(viol_n - v0), 8'h01);
    ctl.des(10);
    v0 = viol_n;
    ctl.send(`CA_WR1, 1'b0, 6'h00);
    ctl.des(16);
    // One clock short of the minimum spacing
    ctl.send(`CA_MRR1, 1'b0, `MR_MODE13); settle();
    check("wtr_edge", 8'(viol_n - v0), 8'h01);
    ctl.des(10);
    v0 = viol_n;
    ctl.send(`CA_WR1, 1'b0, 6'h00);
    // Exactly the minimum spacing from the write command
    ctl.des(17);
    ctl.send(`CA_MRR1, 1'b0, `MR_MODE13);
    ctl.des(10); settle();
    check("wtr_ok", 8'(viol_n - v0), 8'h00);
    $display("test write to read done");
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge ref_clk);
    #1 srst = 1'b0;
    settle();
    t_reset();
    t_vref();
    t_hc();
    t_sr();
    t_mrr();
    t_wtr();
    final_report();
  end
endmodule
`default_nettype wire
